// [design/hpp_port.sv]
// Purpose: Handshake parallel port unit, two byte ports and a split port C
// Assumes: Pins are asynchronous and pass two flip-flops; host port is synchronous
// Notes:   Read data returns one cycle after the read strobe
module hpp_port (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [1:0] bus_addr,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata,
  input  wire logic [7:0] pa_in,
  output logic      [7:0] pa_out,
  output logic      [7:0] pa_oe,
  input  wire logic [7:0] pb_in,
  output logic      [7:0] pb_out,
  output logic      [7:0] pb_oe,
  input  wire logic [7:0] pc_in,
  output logic      [7:0] pc_out,
  output logic      [7:0] pc_oe,
  output logic            irq_a,
  output logic            irq_b
);
  logic [6:0] ctl_ff;
  logic [7:0] pc_ff;
  logic [7:0] rdata_ff;
  logic [7:0] pa_s1_ff, pa_s2_ff, pb_s1_ff, pb_s2_ff;
  logic [7:0] pc_s1_ff, pc_s2_ff, pc_d_ff;
  logic [7:0] out_ff [2];
  logic [7:0] lat_ff [2];
  logic [7:0] din    [2];
  logic [1:0] ibf_ff, obf_ff, intr_ff;
  logic [1:0] in_hs, out_hs, stb_n, stb_pn, ack_n, ack_pn;
  logic [1:0] inte_in, inte_out, wr_g, rd_g;
  logic       mode_wr, bsr_wr, a_m1, a_m2, b_m1, a_in, b_in;
  logic [2:0] bsr_sel;
  logic [7:0] hso_m, hsi_m, gpo_m, gpi_m, pc_hs, pc_rd, pa_rd, pb_rd;
  logic [7:0] nxt_rdata;

  // Host access decode
  assign mode_wr = bus_wr && bus_addr == hpp_pkg::OFS_CW && bus_wdata[hpp_pkg::CW_MODESET];
  assign bsr_wr  = bus_wr && bus_addr == hpp_pkg::OFS_CW && !bus_wdata[hpp_pkg::CW_MODESET];
  assign bsr_sel = bus_wdata[hpp_pkg::CW_SEL_HI:hpp_pkg::CW_SEL_LO];
  assign wr_g[0] = bus_wr && bus_addr == hpp_pkg::OFS_PA;
  assign wr_g[1] = bus_wr && bus_addr == hpp_pkg::OFS_PB;
  assign rd_g[0] = bus_rd && bus_addr == hpp_pkg::OFS_PA;
  assign rd_g[1] = bus_rd && bus_addr == hpp_pkg::OFS_PB;

  // Mode decode, groups independent
  assign a_m2 = ctl_ff[hpp_pkg::CW_A_M2];
  assign a_m1 = !a_m2 && ctl_ff[hpp_pkg::CW_A_M1];
  assign b_m1 = ctl_ff[hpp_pkg::CW_B_M1];
  assign a_in = ctl_ff[hpp_pkg::CW_A_IN];
  assign b_in = ctl_ff[hpp_pkg::CW_B_IN];
  assign in_hs[0]  = a_m2 || (a_m1 && a_in);
  assign out_hs[0] = a_m2 || (a_m1 && !a_in);
  assign in_hs[1]  = b_m1 && b_in;
  assign out_hs[1] = b_m1 && !b_in;

  // Handshake lines and enables taken from port C
  assign stb_n[0]    = pc_s2_ff[hpp_pkg::PC_STB_A];
  assign stb_n[1]    = pc_s2_ff[hpp_pkg::PC_HS_B];
  assign ack_n[0]    = pc_s2_ff[hpp_pkg::PC_ACK_A];
  assign ack_n[1]    = pc_s2_ff[hpp_pkg::PC_HS_B];
  assign stb_pn[0]   = pc_d_ff[hpp_pkg::PC_STB_A];
  assign stb_pn[1]   = pc_d_ff[hpp_pkg::PC_HS_B];
  assign ack_pn[0]   = pc_d_ff[hpp_pkg::PC_ACK_A];
  assign ack_pn[1]   = pc_d_ff[hpp_pkg::PC_HS_B];
  assign inte_in[0]  = pc_ff[hpp_pkg::PC_STB_A];
  assign inte_in[1]  = pc_ff[hpp_pkg::PC_HS_B];
  assign inte_out[0] = pc_ff[hpp_pkg::PC_ACK_A];
  assign inte_out[1] = pc_ff[hpp_pkg::PC_HS_B];
  assign din[0]      = pa_s2_ff;
  assign din[1]      = pb_s2_ff;

  // Pin synchronisers and edge history
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pa_s1_ff <= hpp_pkg::BYTE_ZERO;
      pa_s2_ff <= hpp_pkg::BYTE_ZERO;
      pb_s1_ff <= hpp_pkg::BYTE_ZERO;
      pb_s2_ff <= hpp_pkg::BYTE_ZERO;
      pc_s1_ff <= '1;
      pc_s2_ff <= '1;
      pc_d_ff  <= '1;
    end else begin
      pa_s1_ff <= pa_in;
      pa_s2_ff <= pa_s1_ff;
      pb_s1_ff <= pb_in;
      pb_s2_ff <= pb_s1_ff;
      pc_s1_ff <= pc_in;
      pc_s2_ff <= pc_s1_ff;
      pc_d_ff  <= pc_s2_ff;
    end
  end

  // Mode register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctl_ff <= hpp_pkg::CTL_RST;
    end else if (mode_wr) begin
      ctl_ff <= bus_wdata[hpp_pkg::CW_A_M2:hpp_pkg::CW_CL_IN];
    end
  end

  // Port C latch: direct write to free outputs, single-bit command anywhere
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pc_ff <= hpp_pkg::BYTE_ZERO;
    end else if (mode_wr) begin
      pc_ff <= hpp_pkg::BYTE_ZERO;
    end else if (bsr_wr) begin
      pc_ff[bsr_sel] <= bus_wdata[hpp_pkg::CW_VAL];
    end else if (bus_wr && bus_addr == hpp_pkg::OFS_PC) begin
      pc_ff <= (pc_ff & ~gpo_m) | (bus_wdata & gpo_m);
    end
  end

  // Per-group latches and handshake flags
  for (genvar g = 0; g < 2; g++) begin : g_grp
    logic stb_rise, ack_rise;
    assign stb_rise = in_hs[g] && !stb_pn[g] && stb_n[g];
    assign ack_rise = out_hs[g] && !ack_pn[g] && ack_n[g];
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        out_ff[g]  <= hpp_pkg::BYTE_ZERO;
        lat_ff[g]  <= hpp_pkg::BYTE_ZERO;
        ibf_ff[g]  <= 1'b0;
        obf_ff[g]  <= 1'b0;
        intr_ff[g] <= 1'b0;
      end else if (mode_wr) begin
        out_ff[g]  <= hpp_pkg::BYTE_ZERO;
        lat_ff[g]  <= hpp_pkg::BYTE_ZERO;
        ibf_ff[g]  <= 1'b0;
        obf_ff[g]  <= 1'b0;
        intr_ff[g] <= 1'b0;
      end else begin
        // Output latch holds until rewritten
        if (wr_g[g]) begin
          out_ff[g] <= bus_wdata;
        end
        // Strobe low captures the pins
        if (in_hs[g] && !stb_n[g]) begin
          lat_ff[g] <= din[g];
        end
        // Buffer full: strobe sets, read clears, set wins
        if (in_hs[g] && !stb_n[g]) begin
          ibf_ff[g] <= 1'b1;
        end else if (rd_g[g]) begin
          ibf_ff[g] <= 1'b0;
        end
        // Output full: write sets, acknowledge clears, set wins
        if (out_hs[g] && wr_g[g]) begin
          obf_ff[g] <= 1'b1;
        end else if (out_hs[g] && !ack_n[g]) begin
          obf_ff[g] <= 1'b0;
        end
        // Request: end of strobe or acknowledge, gated by enable
        if ((stb_rise && ibf_ff[g] && inte_in[g]) ||
            (ack_rise && !obf_ff[g] && inte_out[g])) begin
          intr_ff[g] <= 1'b1;
        end else if ((in_hs[g] && rd_g[g]) || (out_hs[g] && wr_g[g])) begin
          intr_ff[g] <= 1'b0;
        end
      end
    end
  end

  // Port C role masks
  always_comb begin
    hso_m = hpp_pkg::BYTE_ZERO;
    hsi_m = hpp_pkg::BYTE_ZERO;
    if (in_hs[0]) begin
      hso_m = hso_m | hpp_pkg::HSO_A_IN;
      hsi_m = hsi_m | hpp_pkg::HSI_A_IN;
    end
    if (out_hs[0]) begin
      hso_m = hso_m | hpp_pkg::HSO_A_OUT;
      hsi_m = hsi_m | hpp_pkg::HSI_A_OUT;
    end
    if (b_m1) begin
      hso_m = hso_m | hpp_pkg::HSO_B;
      hsi_m = hsi_m | hpp_pkg::HSI_B;
    end
  end
  assign gpo_m = {{4{!ctl_ff[hpp_pkg::CW_CU_IN]}}, {4{!ctl_ff[hpp_pkg::CW_CL_IN]}}} & ~(hso_m | hsi_m);
  assign gpi_m = ~gpo_m & ~(hso_m | hsi_m);

  // Handshake output values on port C
  always_comb begin
    pc_hs = hpp_pkg::BYTE_ZERO;
    pc_hs[hpp_pkg::PC_INTR_A] = intr_ff[0];
    pc_hs[hpp_pkg::PC_IBF_A]  = ibf_ff[0];
    pc_hs[hpp_pkg::PC_OBF_A]  = !obf_ff[0];
    pc_hs[hpp_pkg::PC_INTR_B] = intr_ff[1];
    pc_hs[hpp_pkg::PC_FLAG_B] = b_in ? ibf_ff[1] : !obf_ff[1];
  end

  // Pin drive
  assign pc_out = (hso_m & pc_hs) | (~hso_m & pc_ff);
  assign pc_oe  = hso_m | gpo_m;
  assign pa_out = out_ff[0];
  assign pa_oe  = a_m2 ? {8{!ack_n[0]}} : {8{!a_in}};
  assign pb_out = out_ff[1];
  assign pb_oe  = {8{!b_in}};
  assign irq_a  = intr_ff[0];
  assign irq_b  = intr_ff[1];

  // Read values: live pins in basic input, latch in handshake modes
  assign pa_rd = (a_m1 || a_m2) ? lat_ff[0] : (a_in ? pa_s2_ff : out_ff[0]);
  assign pb_rd = b_m1 ? lat_ff[1] : (b_in ? pb_s2_ff : out_ff[1]);
  assign pc_rd = (hsi_m & pc_ff) | (hso_m & pc_hs) | (gpo_m & pc_ff) | (gpi_m & pc_s2_ff);

  // Registered read data
  always_comb begin
    case (bus_addr)
      hpp_pkg::OFS_PA: nxt_rdata = pa_rd;
      hpp_pkg::OFS_PB: nxt_rdata = pb_rd;
      hpp_pkg::OFS_PC: nxt_rdata = pc_rd;
      default:         nxt_rdata = hpp_pkg::BYTE_ZERO;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_ff <= hpp_pkg::BYTE_ZERO;
    end else if (bus_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign bus_rdata = rdata_ff;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_mode_clear;
    mode_wr |=> (ibf_ff == 2'b00) && (intr_ff == 2'b00) && (pc_ff == 8'h00) && (pa_out == 8'h00);
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode set left state");

  property p_bsr_one;
    bsr_wr |=> pc_ff[$past(bsr_sel)] == $past(bus_wdata[0]) &&
               ((pc_ff ^ $past(pc_ff)) & ~(8'h01 << $past(bsr_sel))) == 8'h00;
  endproperty
  a_bsr_one: assert property (p_bsr_one) else $error("bit command wrong");

  property p_cw09;
    bus_wr && bus_addr == 2'h3 && bus_wdata == 8'h09 |=> inte_in[0] ##1 inte_in[0];
  endproperty
  a_cw09: assert property (p_cw09) else $error("0x09 did not enable");

  property p_cw80;
    bus_wr && bus_addr == 2'h3 && bus_wdata == 8'h80 |=> pa_oe == 8'hff && pb_oe == 8'hff && pc_oe == 8'hff;
  endproperty
  a_cw80: assert property (p_cw80) else $error("0x80 not all outputs");

  property p_cw90;
    bus_wr && bus_addr == 2'h3 && bus_wdata == 8'h90 |=> pa_oe == 8'h00 && pb_oe == 8'hff && pc_oe == 8'hff;
  endproperty
  a_cw90: assert property (p_cw90) else $error("0x90 wrong directions");

  property p_live_in;
    !a_m1 && !a_m2 && a_in && !bus_wr && rd_g[0] |=> bus_rdata == $past(pa_s2_ff);
  endproperty
  a_live_in: assert property (p_live_in) else $error("basic input not live");

  property p_out_hold;
    !a_in && !a_m2 && !wr_g[0] && !mode_wr |=> $stable(pa_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output latch moved");

  property p_strobe_in;
    in_hs[0] && !stb_n[0] && !mode_wr |=> ibf_ff[0] && lat_ff[0] == $past(pa_s2_ff);
  endproperty
  a_strobe_in: assert property (p_strobe_in) else $error("strobe did not latch");

  property p_status;
    a_m1 && a_in && bus_rd && bus_addr == 2'h2 |=>
      bus_rdata[5:3] == {$past(ibf_ff[0]), $past(pc_ff[4]), $past(intr_ff[0])};
  endproperty
  a_status: assert property (p_status) else $error("status bits misplaced");

  property p_intr_b;
    in_hs[1] && !stb_pn[1] && stb_n[1] && ibf_ff[1] && inte_in[1] && !mode_wr |=> intr_ff[1] && irq_b;
  endproperty
  a_intr_b: assert property (p_intr_b) else $error("group B request lost");

  property p_bidir_oe;
    a_m2 |-> pa_oe == (ack_n[0] ? 8'h00 : 8'hff) && pc_oe[7:3] == 5'b10101;
  endproperty
  a_bidir_oe: assert property (p_bidir_oe) else $error("bidirectional drive wrong");

  c_intr_a: cover property (in_hs[0] ##1 intr_ff[0]);
  c_bidir:  cover property (a_m2 && !ack_n[0] ##1 obf_ff[0] == 1'b0);
  c_out_b:  cover property (out_hs[1] && wr_g[1] ##[1:20] intr_ff[1]);
  c_bsr:    cover property (bsr_wr && bus_wdata[0]);
endmodule : hpp_port

// [design/hpp_pkg.sv]
// Purpose: Shared constants for the handshake parallel port unit
// Assumes: Byte-wide host register port, four registers
// Notes:   Control-word field positions and port C pin roles
package hpp_pkg;
  // Register offsets
  localparam logic [1:0] OFS_PA     = 2'h0;
  localparam logic [1:0] OFS_PB     = 2'h1;
  localparam logic [1:0] OFS_PC     = 2'h2;
  localparam logic [1:0] OFS_CW     = 2'h3;
  // Control word, mode-set form
  localparam int         CW_MODESET = 7;
  localparam int         CW_A_M2    = 6;
  localparam int         CW_A_M1    = 5;
  localparam int         CW_A_IN    = 4;
  localparam int         CW_CU_IN   = 3;
  localparam int         CW_B_M1    = 2;
  localparam int         CW_B_IN    = 1;
  localparam int         CW_CL_IN   = 0;
  // Control word, single-bit form
  localparam int         CW_SEL_HI  = 3;
  localparam int         CW_SEL_LO  = 1;
  localparam int         CW_VAL     = 0;
  // Reset configuration: basic mode, every section input
  localparam logic [6:0] CTL_RST    = 7'h1b;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // Port C pin roles
  localparam int         PC_INTR_A  = 3;
  localparam int         PC_STB_A   = 4;
  localparam int         PC_IBF_A   = 5;
  localparam int         PC_ACK_A   = 6;
  localparam int         PC_OBF_A   = 7;
  localparam int         PC_INTR_B  = 0;
  localparam int         PC_FLAG_B  = 1;
  localparam int         PC_HS_B    = 2;
  // Port C masks per handshake setup
  localparam logic [7:0] HSO_A_IN   = 8'h28;
  localparam logic [7:0] HSO_A_OUT  = 8'h88;
  localparam logic [7:0] HSI_A_IN   = 8'h10;
  localparam logic [7:0] HSI_A_OUT  = 8'h40;
  localparam logic [7:0] HSO_B      = 8'h03;
  localparam logic [7:0] HSI_B      = 8'h04;
endpackage : hpp_pkg

// [verification/hpp_peer.sv]
// Purpose: Model of the equipment on the port pins
// Assumes: Idle strobe and acknowledge lines sit high
// Notes:   A pin shows the unit's value where it drives, else ours
module hpp_peer (
  input  wire logic       clk_sys,
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pc_out,
  input  wire logic [7:0] pc_oe,
  output logic      [7:0] pa_in,
  output logic      [7:0] pb_in,
  output logic      [7:0] pc_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pa_lvl;
  logic [7:0] pb_lvl;
  logic [7:0] pc_lvl;
  // Resolve each pin from the unit's drive enable, else our level
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_lvl);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_lvl);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & pc_lvl);
  // Handshake lines start idle
  initial begin
    pa_lvl = 8'h00;
    pb_lvl = 8'h00;
    pc_lvl = 8'hff;
  end
  // Three-cycle low pulse on one port C line
  task automatic strobe(input int n);
    @(negedge clk_sys);
    pc_lvl[n] = 1'b0;
    repeat (3) @(negedge clk_sys);
    pc_lvl[n] = 1'b1;
  endtask : strobe
endmodule : hpp_peer

// [verification/tb_handshake_parallel_port.sv]
// Purpose: Self-checking bench for the handshake parallel port unit
// Assumes: Inputs change at the falling clock edge
// Notes:   Random data from a fixed seed, corner cases by hand
module tb_handshake_parallel_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys, resetn, bus_wr, bus_rd, irq_a, irq_b;
  logic [1:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
  logic [7:0] pc_in, pc_out, pc_oe, rv, d, c;
  int         n_errors, checked;
  hpp_port uut (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .pa_in(pa_in),
    .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .irq_a(irq_a), .irq_b(irq_b));
  hpp_peer peer (.clk_sys(clk_sys), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
    .pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));
  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Expected port C after a single-bit command
  function automatic logic [7:0] bsr(input logic [7:0] cur, input logic [7:0] w);
    bsr = cur;
    bsr[w[3:1]] = w[0];
  endfunction : bsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // One-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(negedge clk_sys);
    bus_wr = 1'b0;
  endtask : wr
  // One-cycle register read, data a cycle later
  task automatic rd(input logic [1:0] a);
    @(negedge clk_sys);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk_sys);
    bus_rd = 1'b0;
    rv = bus_rdata;
  endtask : rd
  task automatic close_out;
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // Watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  // Main sequence
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 2'h0;
    bus_wdata = 8'h00;
    n_errors = 0;
    checked = 0;
    resetn = 1'b0;
    void'($urandom(32'h4d85b7fc));
    tick(12);
    resetn = 1'b1;
    chk(pa_oe | pb_oe | pc_oe, 8'h00);
    chk(pa_out | pb_out, 8'h00);
    rd(hpp_pkg::OFS_CW);
    chk(rv, 8'h00);
    // Every basic direction combination
    for (int i = 0; i < 16; i++) begin
      c = 8'h80 | {3'h0, i[3], i[2], 1'b0, i[1], i[0]};
      wr(hpp_pkg::OFS_CW, c);
      chk(pa_oe, {8{~c[hpp_pkg::CW_A_IN]}});
      chk(pb_oe, {8{~c[hpp_pkg::CW_B_IN]}});
      chk(pc_oe, {{4{~c[hpp_pkg::CW_CU_IN]}}, {4{~c[hpp_pkg::CW_CL_IN]}}});
    end
    // All outputs, latched values
    wr(hpp_pkg::OFS_CW, 8'h80);
    d = 8'($urandom);
    c = d ^ 8'h5a;
    wr(hpp_pkg::OFS_PA, d);
    wr(hpp_pkg::OFS_PB, ~d);
    wr(hpp_pkg::OFS_PC, c);
    tick(4);
    chk(pa_out, d);
    chk(pb_out, ~d);
    chk(pc_out, c);
    // Random single-bit commands on port C
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom) & 8'h0f;
      wr(hpp_pkg::OFS_CW, d);
      c = bsr(c, d);
      chk(pc_out, c);
    end
    // Mode set clears latches; port A reads live pins
    wr(hpp_pkg::OFS_CW, 8'h90);
    chk(pb_out, 8'h00);
    chk(pa_oe, 8'h00);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      peer.pa_lvl = d;
      tick(3);
      rd(hpp_pkg::OFS_PA);
      chk(rv, d);
    end
    // Group A strobed input with its request enabled
    wr(hpp_pkg::OFS_CW, 8'hb0);
    wr(hpp_pkg::OFS_CW, 8'h09);
    d = 8'($urandom);
    peer.pa_lvl = d;
    peer.strobe(hpp_pkg::PC_STB_A);
    peer.pa_lvl = ~d;
    tick(4);
    chk(8'(irq_a), 8'h01);
    rd(hpp_pkg::OFS_PC);
    chk(rv & 8'h38, 8'h38);
    rd(hpp_pkg::OFS_PA);
    chk(rv, d);
    chk(8'(irq_a), 8'h00);
    // Enable withdrawn: flag sets, no request
    wr(hpp_pkg::OFS_CW, 8'h08);
    peer.strobe(hpp_pkg::PC_STB_A);
    tick(4);
    chk(8'(irq_a), 8'h00);
    rd(hpp_pkg::OFS_PC);
    chk(rv & 8'h38, 8'h20);
    // Group B strobed input beside basic output on group A
    wr(hpp_pkg::OFS_CW, 8'h86);
    wr(hpp_pkg::OFS_CW, 8'h05);
    d = 8'($urandom);
    peer.pb_lvl = d;
    peer.strobe(hpp_pkg::PC_HS_B);
    tick(4);
    chk(pa_oe, 8'hff);
    chk(8'(irq_b), 8'h01);
    rd(hpp_pkg::OFS_PB);
    chk(rv, d);
    chk(8'(irq_b), 8'h00);
    // Group B strobed output, acknowledge then request
    wr(hpp_pkg::OFS_CW, 8'h84);
    wr(hpp_pkg::OFS_CW, 8'h05);
    d = 8'($urandom);
    wr(hpp_pkg::OFS_PB, d);
    chk(pb_out, d);
    chk(pc_out & 8'h02, 8'h00);
    peer.strobe(hpp_pkg::PC_HS_B);
    tick(4);
    chk(pc_out & 8'h02, 8'h02);
    chk(8'(irq_b), 8'h01);
    // Group A strobed output, acknowledge then request
    wr(hpp_pkg::OFS_CW, 8'ha0);
    wr(hpp_pkg::OFS_CW, 8'h0d);
    d = 8'($urandom);
    wr(hpp_pkg::OFS_PA, d);
    chk(pa_out, d);
    chk(pc_out & 8'h80, 8'h00);
    peer.strobe(hpp_pkg::PC_ACK_A);
    tick(4);
    chk(pc_out & 8'h80, 8'h80);
    chk(8'(irq_a), 8'h01);
    // Bidirectional port A drives only while acknowledged
    wr(hpp_pkg::OFS_CW, 8'hc0);
    chk(pa_oe, 8'h00);
    peer.pc_lvl[hpp_pkg::PC_ACK_A] = 1'b0;
    tick(3);
    chk(pa_oe, 8'hff);
    peer.pc_lvl[hpp_pkg::PC_ACK_A] = 1'b1;
    tick(3);
    chk(pa_oe, 8'h00);
    // Bidirectional input through the strobe, output through the latch
    wr(hpp_pkg::OFS_CW, 8'h09);
    d = 8'($urandom);
    peer.pa_lvl = d;
    peer.strobe(hpp_pkg::PC_STB_A);
    tick(4);
    chk(8'(irq_a), 8'h01);
    rd(hpp_pkg::OFS_PA);
    chk(rv, d);
    wr(hpp_pkg::OFS_PA, ~d);
    chk(pc_out & 8'h80, 8'h00);
    chk(pa_out, ~d);
    close_out();
  end
endmodule : tb_handshake_parallel_port
